/* File: hw/cac_map.svh */
// register offsets, field ranges, masks and limits of the calendar clock
`ifndef CAC_MAP_SVH
`define CAC_MAP_SVH
`define CAC_OFF_DIV 6'h00
`define CAC_OFF_LDATE 6'h04
`define CAC_OFF_LTIME 6'h08
`define CAC_OFF_CTRL 6'h0c
`define CAC_OFF_ADATE 6'h10
`define CAC_OFF_ATIME 6'h14
`define CAC_OFF_CDATE 6'h18
`define CAC_OFF_CTIME 6'h1c
`define CAC_OFF_RAW 6'h20
`define CAC_OFF_INTE 6'h24
`define CAC_OFF_INTERRUPT_FORCE 6'h28
`define CAC_OFF_INTERRUPT_STATUS 6'h2c
`define CAC_YEAR_F 23:12
`define CAC_MONTH_F 11:8
`define CAC_DAY_F 4:0
`define CAC_DOTW_F 26:24
`define CAC_HOUR_F 20:16
`define CAC_MIN_F 13:8
`define CAC_SEC_F 5:0
`define CAC_DIV_F 15:0
`define CAC_CTRL_EN 0
`define CAC_CTRL_LOAD 4
`define CAC_CTRL_LEAP 8
`define CAC_GEN_BIT 28
`define CAC_YEAR_ENA 26
`define CAC_MONTH_ENA 25
`define CAC_DAY_ENA 24
`define CAC_DOTW_ENA 31
`define CAC_HOUR_ENA 30
`define CAC_MIN_ENA 29
`define CAC_SEC_ENA 28
`define CAC_IRQ_BIT 0
`define CAC_ZERO32 32'h0000_0000
`define CAC_MASK_DIV 32'h0000_ffff
`define CAC_MASK_DATE 32'h00ff_ff1f
`define CAC_MASK_TIME 32'h071f_3f3f
`define CAC_MASK_CTRL 32'h0000_0101
`define CAC_MASK_ADATE 32'h17ff_ff1f
`define CAC_MASK_ATIME 32'hf71f_3f3f
`define CAC_MASK_IRQ 32'h0000_0001
`define CAC_SEC_MAX 6'h3b
`define CAC_MIN_MAX 6'h3b
`define CAC_HOUR_MAX 5'h17
`define CAC_DOTW_MAX 3'h6
`define CAC_MON_MAX 4'hc
`define CAC_FEB 4'h2
`define CAC_APR 4'h4
`define CAC_JUN 4'h6
`define CAC_SEP 4'h9
`define CAC_NOV 4'hb
`define CAC_DAY_28 5'h1c
`define CAC_DAY_29 5'h1d
`define CAC_DAY_30 5'h1e
`define CAC_DAY_31 5'h1f
`define CAC_DAY_FIRST 5'h01
`define CAC_MON_FIRST 4'h1
`define CAC_LEAP_F 1:0
`define CAC_LEAP_REM 2'h0
`endif

/* File: hw/cac_pkg.sv */
// field types of the calendar clock
package cac_pkg;
   typedef logic [11:0] cac_year_t;
   typedef logic [3:0] cac_month_t;
   typedef logic [4:0] cac_day_t;
   typedef logic [2:0] cac_dotw_t;
   typedef logic [4:0] cac_hour_t;
   typedef logic [5:0] cac_min_t;
   typedef logic [15:0] cac_div_t;
endpackage

/* File: hw/cac_clock.sv */
// calendar clock with alarm, register port and reference pin divider
`timescale 1ns/100ps
`include "cac_map.svh"

// Notes on behaviour
// - alarm compares only enabled fields
// - alarm interrupt raises a wake-up request
// - dormant wake needs pin reference, preset alarm
// - divider: 16 bits, ratio minus one, zero
// - date setup: year, month, day fields
// - time setup: weekday, hour, minute, second
// - weekday Sunday zero through Saturday six
// - leap override suppresses February 29
// - run enable; active bit after crossing
// - load bit self-clears, loads setup values
// - twelve words from offset zero
// - status is raw and enable, or force
// - reading time snapshots the date
// - year divisible by four gives Feb 29
// - tick divides reference by value plus one
// - load works while running
module cac_clock
   import cac_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic ref_clk_pin,
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic irq_out,
   output logic wake_out
);

   // reference pin synchroniser and edge detect
   logic ref_s1_reg, ref_s2_reg, ref_s3_reg, ref_lvl_reg;
   wire ref_agree = ref_s2_reg == ref_s3_reg;
   wire ref_edge = ref_agree && ref_s3_reg && !ref_lvl_reg;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         ref_lvl_reg <= 1'b0;
      end else begin
         ref_s1_reg <= ref_clk_pin;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         if (ref_agree) begin
            ref_lvl_reg <= ref_s3_reg;
         end
      end
   end

   // software registers
   logic [31:0] div_reg, ldate_reg, ltime_reg, ctrl_reg;
   logic [31:0] adate_reg, atime_reg, inte_reg, interrupt_force_reg;
   logic [31:0] snap_reg;
   logic load_pend_reg, active_reg, raw_reg, wake_reg;

   wire wr_div = reg_wr && reg_addr == `CAC_OFF_DIV;
   wire wr_ldate = reg_wr && reg_addr == `CAC_OFF_LDATE;
   wire wr_ltime = reg_wr && reg_addr == `CAC_OFF_LTIME;
   wire wr_ctrl = reg_wr && reg_addr == `CAC_OFF_CTRL;
   wire wr_adate = reg_wr && reg_addr == `CAC_OFF_ADATE;
   wire wr_atime = reg_wr && reg_addr == `CAC_OFF_ATIME;
   wire wr_inte = reg_wr && reg_addr == `CAC_OFF_INTE;
   wire wr_interrupt_force = reg_wr && reg_addr == `CAC_OFF_INTERRUPT_FORCE;
   wire rd_ctime = reg_rd && reg_addr == `CAC_OFF_CTIME;
   wire load_set = wr_ctrl && reg_wdata[`CAC_CTRL_LOAD];
   wire load_apply = load_pend_reg && ref_edge;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_reg <= `CAC_ZERO32;
         ldate_reg <= `CAC_ZERO32;
         ltime_reg <= `CAC_ZERO32;
         ctrl_reg <= `CAC_ZERO32;
         adate_reg <= `CAC_ZERO32;
         atime_reg <= `CAC_ZERO32;
         inte_reg <= `CAC_ZERO32;
         interrupt_force_reg <= `CAC_ZERO32;
      end else begin
         if (wr_div)
            div_reg <= reg_wdata & `CAC_MASK_DIV;
         if (wr_ldate)
            ldate_reg <= reg_wdata & `CAC_MASK_DATE;
         if (wr_ltime)
            ltime_reg <= reg_wdata & `CAC_MASK_TIME;
         if (wr_ctrl)
            ctrl_reg <= reg_wdata & `CAC_MASK_CTRL;
         if (wr_adate)
            adate_reg <= reg_wdata & `CAC_MASK_ADATE;
         if (wr_atime)
            atime_reg <= reg_wdata & `CAC_MASK_ATIME;
         if (wr_inte)
            inte_reg <= reg_wdata & `CAC_MASK_IRQ;
         if (wr_interrupt_force)
            interrupt_force_reg <= reg_wdata & `CAC_MASK_IRQ;
      end
   end

   // load request waits for the next reference edge; a new request wins
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         load_pend_reg <= 1'b0;
      end else if (load_set) begin
         load_pend_reg <= 1'b1;
      end else if (load_apply) begin
         load_pend_reg <= 1'b0;
      end
   end

   // run enable takes effect on a reference edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         active_reg <= 1'b0;
      end else if (ref_edge) begin
         active_reg <= ctrl_reg[`CAC_CTRL_EN];
      end
   end

   // one-second divider
   cac_div_t cnt_reg;
   wire cnt_zero = cnt_reg == div_reg[`CAC_DIV_F];
   wire tick = ref_edge && active_reg && cnt_zero;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= '0;
      end else if (!active_reg || tick) begin
         cnt_reg <= '0;
      end else if (ref_edge) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // time counters
   cac_year_t year_reg;
   cac_month_t mon_reg;
   cac_day_t day_reg;
   cac_dotw_t dotw_reg;
   cac_hour_t hour_reg;
   cac_min_t min_reg, sec_reg;

   wire is_leap = year_reg[`CAC_LEAP_F] == `CAC_LEAP_REM
      && !ctrl_reg[`CAC_CTRL_LEAP];
   wire short_mon = mon_reg == `CAC_APR || mon_reg == `CAC_JUN
      || mon_reg == `CAC_SEP || mon_reg == `CAC_NOV;
   wire cac_day_t feb_last = is_leap ? `CAC_DAY_29 : `CAC_DAY_28;
   wire cac_day_t mon_last = mon_reg == `CAC_FEB ? feb_last
      : short_mon ? `CAC_DAY_30 : `CAC_DAY_31;

   wire sec_wrap = sec_reg == `CAC_SEC_MAX;
   wire min_wrap = min_reg == `CAC_MIN_MAX;
   wire hour_wrap = hour_reg == `CAC_HOUR_MAX;
   wire day_wrap = day_reg == mon_last;
   wire mon_wrap = mon_reg == `CAC_MON_MAX;
   wire dotw_wrap = dotw_reg == `CAC_DOTW_MAX;
   wire c_min = sec_wrap;
   wire c_hour = c_min && min_wrap;
   wire c_day = c_hour && hour_wrap;
   wire c_mon = c_day && day_wrap;
   wire c_year = c_mon && mon_wrap;

   wire cac_min_t sec_next = sec_wrap ? '0 : sec_reg + 6'h01;
   wire cac_min_t min_next = !c_min ? min_reg
      : min_wrap ? '0 : min_reg + 6'h01;
   wire cac_hour_t hour_next = !c_hour ? hour_reg
      : hour_wrap ? '0 : hour_reg + 5'h01;
   wire cac_dotw_t dotw_next = !c_day ? dotw_reg
      : dotw_wrap ? '0 : dotw_reg + 3'h1;
   wire cac_day_t day_next = !c_day ? day_reg
      : day_wrap ? `CAC_DAY_FIRST : day_reg + 5'h01;
   wire cac_month_t mon_next = !c_mon ? mon_reg
      : mon_wrap ? `CAC_MON_FIRST : mon_reg + 4'h1;
   wire cac_year_t year_next = c_year ? year_reg + 12'h001 : year_reg;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         year_reg <= '0;
         mon_reg <= '0;
         day_reg <= '0;
         dotw_reg <= '0;
         hour_reg <= '0;
         min_reg <= '0;
         sec_reg <= '0;
      end else if (load_apply) begin
         year_reg <= ldate_reg[`CAC_YEAR_F];
         mon_reg <= ldate_reg[`CAC_MONTH_F];
         day_reg <= ldate_reg[`CAC_DAY_F];
         dotw_reg <= ltime_reg[`CAC_DOTW_F];
         hour_reg <= ltime_reg[`CAC_HOUR_F];
         min_reg <= ltime_reg[`CAC_MIN_F];
         sec_reg <= ltime_reg[`CAC_SEC_F];
      end else if (tick) begin
         year_reg <= year_next;
         mon_reg <= mon_next;
         day_reg <= day_next;
         dotw_reg <= dotw_next;
         hour_reg <= hour_next;
         min_reg <= min_next;
         sec_reg <= sec_next;
      end
   end

   // alarm compare on the counters one cycle after each tick
   logic tick_d_reg;
   wire gen = adate_reg[`CAC_GEN_BIT];
   wire m_year = !adate_reg[`CAC_YEAR_ENA]
      || adate_reg[`CAC_YEAR_F] == year_reg;
   wire m_mon = !adate_reg[`CAC_MONTH_ENA]
      || adate_reg[`CAC_MONTH_F] == mon_reg;
   wire m_day = !adate_reg[`CAC_DAY_ENA]
      || adate_reg[`CAC_DAY_F] == day_reg;
   wire m_dotw = !atime_reg[`CAC_DOTW_ENA]
      || atime_reg[`CAC_DOTW_F] == dotw_reg;
   wire m_hour = !atime_reg[`CAC_HOUR_ENA]
      || atime_reg[`CAC_HOUR_F] == hour_reg;
   wire m_min = !atime_reg[`CAC_MIN_ENA]
      || atime_reg[`CAC_MIN_F] == min_reg;
   wire m_sec = !atime_reg[`CAC_SEC_ENA]
      || atime_reg[`CAC_SEC_F] == sec_reg;
   wire all_match = m_year && m_mon && m_day && m_dotw
      && m_hour && m_min && m_sec;
   wire int_status = (raw_reg && inte_reg[`CAC_IRQ_BIT])
      || interrupt_force_reg[`CAC_IRQ_BIT];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tick_d_reg <= 1'b0;
         raw_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         tick_d_reg <= tick;
         wake_reg <= int_status;
         if (!gen) begin
            raw_reg <= 1'b0;
         end else if (tick_d_reg) begin
            raw_reg <= all_match;
         end
      end
   end

   assign irq_out = int_status;
   assign wake_out = wake_reg;

   // read path
   wire [31:0] cdate_now = {8'h00, year_reg, mon_reg, 3'h0,
      day_reg};
   wire [31:0] ctime_now = {5'h00, dotw_reg, 3'h0, hour_reg, 2'h0,
      min_reg, 2'h0, sec_reg};
   wire [31:0] ctrl_rd = {ctrl_reg[31:5], load_pend_reg,
      ctrl_reg[3:2], active_reg, ctrl_reg[0]};
   wire [31:0] adate_rd = {adate_reg[31:30], raw_reg, adate_reg[28:0]};
   wire [31:0] raw_rd = {31'h0000_0000, raw_reg};
   wire [31:0] interrupt_status_rd = {31'h0000_0000, int_status};
   wire [31:0] rd_mux =
      reg_addr == `CAC_OFF_DIV ? div_reg
      : reg_addr == `CAC_OFF_LDATE ? ldate_reg
      : reg_addr == `CAC_OFF_LTIME ? ltime_reg
      : reg_addr == `CAC_OFF_CTRL ? ctrl_rd
      : reg_addr == `CAC_OFF_ADATE ? adate_rd
      : reg_addr == `CAC_OFF_ATIME ? atime_reg
      : reg_addr == `CAC_OFF_CDATE ? snap_reg
      : reg_addr == `CAC_OFF_CTIME ? ctime_now
      : reg_addr == `CAC_OFF_RAW ? raw_rd
      : reg_addr == `CAC_OFF_INTE ? inte_reg
      : reg_addr == `CAC_OFF_INTERRUPT_FORCE ? interrupt_force_reg
      : reg_addr == `CAC_OFF_INTERRUPT_STATUS ? interrupt_status_rd
      : `CAC_ZERO32;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= `CAC_ZERO32;
         snap_reg <= `CAC_ZERO32;
      end else begin
         if (reg_rd)
            reg_rdata <= rd_mux;
         if (rd_ctime)
            snap_reg <= cdate_now;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   a_raw_needs_gen:
   assert property (raw_reg |-> $past(gen))
      else $error("raw flag set without global enable");

   a_field_mismatch:
   assert property (tick_d_reg && gen && atime_reg[`CAC_SEC_ENA]
      && atime_reg[`CAC_SEC_F] != sec_reg |=> !raw_reg)
      else $error("alarm raised with a mismatching enabled field");

   a_irq_status:
   assert property (irq_out |-> (raw_reg && inte_reg[`CAC_IRQ_BIT])
      || interrupt_force_reg[`CAC_IRQ_BIT])
      else $error("interrupt without raw and enable or force");

   a_wake_follow:
   assert property ($rose(irq_out) |=> wake_out)
      else $error("wake-up did not follow interrupt");

   a_load_clears:
   assert property (load_apply && !load_set |=> !load_pend_reg)
      else $error("load bit did not self-clear");

   a_active_lag:
   assert property ($rose(active_reg) |-> $past(ref_edge)
      && $past(ctrl_reg[`CAC_CTRL_EN]))
      else $error("active rose without enable on a reference edge");

   a_div_period:
   assert property (tick |-> cnt_reg == div_reg[`CAC_DIV_F])
      else $error("tick before divider count complete");

   a_leap_day:
   assert property (tick && !load_apply && c_day && mon_reg == `CAC_FEB
      && day_reg == `CAC_DAY_28 && is_leap |=> day_reg == `CAC_DAY_29)
      else $error("leap year did not reach February 29");

   a_noleap_day:
   assert property (tick && c_day && mon_reg == `CAC_FEB
      && day_reg == `CAC_DAY_28 && ctrl_reg[`CAC_CTRL_LEAP]
      |=> day_reg == `CAC_DAY_FIRST || $past(load_apply))
      else $error("leap override ignored");

   a_date_snapshot:
   assert property (rd_ctime |=> snap_reg == $past(cdate_now))
      else $error("date snapshot not taken on time read");

endmodule // cac_clock

/* File: dv/tb_top.sv */
// self-checking bench for the calendar clock with alarm
`timescale 1ns/100ps
`include "cac_map.svh"
module tb_top;
   logic core_clk;
   logic reset;
   logic ref_clk_pin;
   logic [5:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic irq_out;
   logic wake_out;
   logic rd_d;
   logic [31:0] exp_q[$];
   logic [31:0] seed;
   logic [5:0] offs [6];
   logic [31:0] msks [6];
   int failures;
   int checked;

   cac_clock dut_u (
      .core_clk(core_clk),
      .reset(reset),
      .ref_clk_pin(ref_clk_pin),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .irq_out(irq_out),
      .wake_out(wake_out)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // note the expected word, then issue the read
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask

   // one reference period, long enough for crossing and alarm update
   task automatic ref_pulse;
      repeat (8) @(posedge core_clk);
      ref_clk_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      ref_clk_pin <= 1'b0;
   endtask

   task automatic chk_irq(input logic i, input logic w);
      @(negedge core_clk);
      check({31'h0, irq_out}, {31'h0, i});
      check({31'h0, wake_out}, {31'h0, w});
   endtask

   // read results are compared against the oldest note
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(reg_rdata, 32'hxxxx_xxxx);
         end else begin
            check(reg_rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      tally_and_finish;
   end

   initial begin
      reset = 1'b1;
      ref_clk_pin = 1'b0;
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
      rd_d = 1'b0;
      failures = 0;
      checked = 0;
      seed = 32'h0000_0040;
      offs = '{`CAC_OFF_DIV, `CAC_OFF_LDATE, `CAC_OFF_LTIME,
               `CAC_OFF_ADATE, `CAC_OFF_ATIME, `CAC_OFF_INTE};
      msks = '{`CAC_MASK_DIV, `CAC_MASK_DATE, `CAC_MASK_TIME,
               `CAC_MASK_ADATE, `CAC_MASK_ATIME, `CAC_MASK_IRQ};
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      // reset values, then the unmapped words above the map
      for (int i = 0; i < 16; i++) begin
         rd(6'(i * 4), 32'h0000_0000);
      end
      for (int n = 0; n < 3; n++) begin
         for (int j = 0; j < 6; j++) begin
            seed = xs(seed);
            wr(offs[j], seed);
            rd(offs[j], seed & msks[j]);
         end
      end
      wr(6'h30, 32'hffff_ffff);
      rd(6'h30, 32'h0000_0000);
      wr(`CAC_OFF_ADATE, 32'h0000_0000);
      wr(`CAC_OFF_INTE, 32'h0000_0000);
      wr(`CAC_OFF_INTERRUPT_FORCE, 32'h0000_0001);
      chk_irq(1'b1, 1'b0);
      chk_irq(1'b1, 1'b1);
      rd(`CAC_OFF_INTERRUPT_STATUS, 32'h0000_0001);
      wr(`CAC_OFF_INTERRUPT_FORCE, 32'h0000_0000);
      chk_irq(1'b0, 1'b1);
      chk_irq(1'b0, 1'b0);
      // leap year: 2024 Feb 28, Saturday 23:59:59
      wr(`CAC_OFF_DIV, 32'h0000_0000);
      wr(`CAC_OFF_LDATE, 32'h007e_821c);
      wr(`CAC_OFF_LTIME, 32'h0617_3b3b);
      wr(`CAC_OFF_CTRL, 32'h0000_0010);
      rd(`CAC_OFF_CTRL, 32'h0000_0010);
      ref_pulse;
      rd(`CAC_OFF_CTRL, 32'h0000_0000);
      rd(`CAC_OFF_CTIME, 32'h0617_3b3b);
      rd(`CAC_OFF_CDATE, 32'h007e_821c);
      wr(`CAC_OFF_ADATE, 32'h1000_0000);
      wr(`CAC_OFF_ATIME, 32'h1000_0000);
      wr(`CAC_OFF_INTE, 32'h0000_0001);
      wr(`CAC_OFF_CTRL, 32'h0000_0001);
      ref_pulse;
      rd(`CAC_OFF_CTRL, 32'h0000_0003);
      chk_irq(1'b0, 1'b0);
      ref_pulse;
      rd(`CAC_OFF_CTIME, 32'h0000_0000);
      rd(`CAC_OFF_CDATE, 32'h007e_821d);
      rd(`CAC_OFF_RAW, 32'h0000_0001);
      rd(`CAC_OFF_ADATE, 32'h3000_0000);
      rd(`CAC_OFF_INTERRUPT_STATUS, 32'h0000_0001);
      chk_irq(1'b1, 1'b1);
      wr(`CAC_OFF_INTE, 32'h0000_0000);
      chk_irq(1'b0, 1'b1);
      rd(`CAC_OFF_RAW, 32'h0000_0001);
      // next second no longer matches the enabled seconds field
      ref_pulse;
      rd(`CAC_OFF_CTIME, 32'h0000_0001);
      rd(`CAC_OFF_RAW, 32'h0000_0000);
      wr(`CAC_OFF_ADATE, 32'h0000_0000);
      rd(`CAC_OFF_RAW, 32'h0000_0000);
      // leap override, divide by two, stopped before the change
      wr(`CAC_OFF_CTRL, 32'h0000_0000);
      ref_pulse;
      rd(`CAC_OFF_CTRL, 32'h0000_0000);
      wr(`CAC_OFF_DIV, 32'h0000_0001);
      wr(`CAC_OFF_LDATE, 32'h007e_821c);
      wr(`CAC_OFF_LTIME, 32'h0617_3b3b);
      wr(`CAC_OFF_CTRL, 32'h0000_0110);
      ref_pulse;
      wr(`CAC_OFF_CTRL, 32'h0000_0101);
      ref_pulse;
      rd(`CAC_OFF_CTRL, 32'h0000_0103);
      ref_pulse;
      rd(`CAC_OFF_CTIME, 32'h0617_3b3b);
      ref_pulse;
      rd(`CAC_OFF_CTIME, 32'h0000_0000);
      rd(`CAC_OFF_CDATE, 32'h007e_8301);
      // load while running, on an edge without a tick
      wr(`CAC_OFF_LTIME, 32'h0102_0304);
      wr(`CAC_OFF_CTRL, 32'h0000_0111);
      ref_pulse;
      rd(`CAC_OFF_CTIME, 32'h0102_0304);
      rd(`CAC_OFF_CTRL, 32'h0000_0103);
      repeat (4) @(posedge core_clk);
      tally_and_finish;
   end
endmodule // tb_top
